// File: design/adc_seq_pkg.sv
// shared constants and types for the adc sequencer configuration block
package adc_seq_pkg;
  localparam int NUM_CHAN = 8;
  localparam int NUM_SW = 30;
  // register word addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SAMPLE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_START_CTRL = 8'h08;
  localparam logic [7:0] ADDR_CHAN_EN = 8'h0c;
  localparam logic [7:0] ADDR_FW_SWITCH = 8'h10;
  localparam logic [7:0] ADDR_HW_SWITCH = 8'h14;
  localparam logic [7:0] ADDR_INTR = 8'h18;
  localparam logic [7:0] ADDR_INTR_SET = 8'h1c;
  localparam logic [7:0] ADDR_INTR_MASK = 8'h20;
  localparam logic [7:0] ADDR_INTR_MASKED = 8'h24;
  localparam logic [7:0] ADDR_CAUSE = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2c;
  localparam logic [7:0] ADDR_CHAN_CFG0 = 8'h40;
  // field positions
  localparam int NEGATIVE_INPUT_SELECT_LSB = 9;
  localparam int NEGATIVE_INPUT_SELECT_W = 3;
  localparam int SW_DISABLE_BIT = 30;
  localparam int FABRIC_MODE_BIT = 29;
  localparam int SUB_RES_BIT = 0;
  localparam int CONT_BIT = 16;
  localparam int START_BIT = 0;
  localparam int CFG_DIFF_BIT = 8;
  localparam int CFG_RES_BIT = 9;
  localparam int CFG_AVG_BIT = 10;
  localparam int CFG_ST_LSB = 12;
  localparam int CFG_FWD_BIT = 30;
  // interrupt bit positions
  localparam int INT_EOS = 0;
  localparam int INT_OVF = 1;
  localparam int INT_COLL = 2;
  localparam int INT_INJ = 3;
  localparam int INT_RANGE = 4;
  localparam int INT_SAT = 5;
  localparam int NUM_INT = 6;
  localparam logic [2:0] NEGATIVE_INPUT_SELECT_VREF = 3'h7;
  localparam logic [3:0] CONV_CYCLES = 4'h4;
  typedef enum logic [1:0] {RES_12, RES_10, RES_8} res_t;
  // per channel settings as the sequencer consumes them
  typedef struct packed {
    logic diff;
    logic [1:0] st_sel;
    res_t res;
    logic fwd;
  } chan_sel_t;
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage : adc_seq_pkg

// File: design/adc_res_decode.sv
// channel resolution and settings decoder
`timescale 1ns/1ps
module adc_res_decode
  import adc_seq_pkg::*;
(
  // configuration
  input wire logic [31:0] cfg_in,
  input wire logic sub_res_in,
  // decoded settings
  output chan_sel_t sel_out
);
  // averaging forces full width, then the select bit picks alternate
  always_comb begin
    sel_out.diff = cfg_in[CFG_DIFF_BIT];
    sel_out.st_sel = cfg_in[CFG_ST_LSB +: 2];
    sel_out.fwd = cfg_in[CFG_FWD_BIT];
    if (cfg_in[CFG_AVG_BIT]) begin
      sel_out.res = RES_12;
    end else if (!cfg_in[CFG_RES_BIT]) begin
      sel_out.res = RES_12;
    end else begin
      sel_out.res = sub_res_in ? RES_10 : RES_8;
    end
  end
endmodule : adc_res_decode

// File: design/adc_seq_config.sv
// register mode configuration, routing and scan control of the adc sequencer
//
// Functional notes
// - firmware owns input mux after reset
// - hardware ownership bit hands switch to sequencer
// - switch disable blocks sequencer, not firmware
// - negative select only single-ended sequencer
// - global settings apply to every channel
// - channel picks diff, time, res, avg, forward
// - sub-resolution bit picks eight or ten
// - clear select bit converts at twelve
// - averaging forces twelve bit
// - disabled channel config cannot disturb scan
// - scan visits every enabled channel
// - enables captured at scan start
// - six maskable interrupt sources
// - request, set, mask, masked registers
// - cause register summarises all masked pending sources in one bit
// - firmware, fabric or continuous triggers start scan
// - fabric mode uses fabric configuration
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module adc_seq_config
  import adc_seq_pkg::*;
#(
  parameter int CHANS = NUM_CHAN
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // fabric side
  input wire logic fabric_trig_in,
  input wire logic [31:0] fabric_cfg_in,
  // converter event inputs
  input wire logic range_evt_in,
  input wire logic sat_evt_in,
  input wire logic overflow_evt_in,
  input wire logic collision_evt_in,
  input wire logic inj_eoc_evt_in,
  // routing and conversion outputs
  output logic [NUM_SW-1:0] switch_out,
  output logic [2:0] negative_input_select_out,
  output logic conv_start_out,
  output logic [2:0] conv_chan_out,
  output chan_sel_t conv_sel_out,
  output logic busy_out,
  output logic irq_out
);
  // the address map and status word assume the packaged channel count
  if (CHANS != NUM_CHAN) begin : g_chan_check
    $error("only eight channels are supported");
  end

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] sample_ctrl;
    logic [NUM_CHAN-1:0] chan_en;
    logic [NUM_SW-1:0] fw_sw;
    logic [NUM_SW-1:0] hw_sw;
    logic [NUM_INT-1:0] intr;
    logic [NUM_INT-1:0] mask;
    logic [NUM_CHAN-1:0] scan_en;
    logic [2:0] chan;
    logic [3:0] cnt;
    logic busy;
    logic start_req;
    logic [1:0] trig_sync;
    logic trig_prev;
    logic [31:0] rdata;
    logic [NUM_SW-1:0] sw;
    logic [2:0] neg;
    logic conv_start;
    logic [2:0] conv_chan;
    chan_sel_t conv_sel;
    logic irq;
  } state_t;

  state_t st_ff, nxt_st;
  logic [31:0] chan_cfg_ff [NUM_CHAN];
  chan_sel_t dec_sel;
  logic [31:0] cur_cfg;

  // find next enabled channel at or above a start index
  function automatic logic [3:0] next_chan(input logic [NUM_CHAN-1:0] en, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h8;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (en[i] && (4'(i) >= from)) r = 4'(i);
    end
    return r;
  endfunction : next_chan

  // channel config registers live in an array, not in the state word
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (!rst_n_in) begin
        chan_cfg_ff[i] <= 32'h0000_0000;
      end else if (wr_in && addr_in == ADDR_CHAN_CFG0 + 8'(4 * i)) begin
        chan_cfg_ff[i] <= wdata_in;
      end
    end
  end

  // fabric mode swaps channel config for the fabric word
  assign cur_cfg = st_ff.ctrl[FABRIC_MODE_BIT] ? fabric_cfg_in : chan_cfg_ff[st_ff.chan];

  adc_res_decode u_dec (
    .cfg_in(cur_cfg),
    .sub_res_in(st_ff.sample_ctrl[SUB_RES_BIT]),
    .sel_out(dec_sel)
  );

  // main next-state logic
  always_comb begin
    logic [3:0] nc;
    logic trig_edge;
    logic [NUM_INT-1:0] ev;
    logic [NUM_CHAN-1:0] en_now;
    logic [NUM_SW-1:0] seq_sw;
    nc = 4'h0;
    ev = '0;
    seq_sw = '0;
    trig_edge = st_ff.trig_sync[1] && !st_ff.trig_prev;
    en_now = st_ff.ctrl[FABRIC_MODE_BIT] ? {NUM_CHAN{1'b1}} : st_ff.chan_en;
    nxt_st = st_ff;
    nxt_st.conv_start = 1'b0;
    nxt_st.rdata = 32'h0000_0000;
    nxt_st.trig_sync = {st_ff.trig_sync[0], fabric_trig_in};
    nxt_st.trig_prev = st_ff.trig_sync[1];
    // register writes
    if (wr_in) begin
      case (addr_in)
        ADDR_CTRL: nxt_st.ctrl = wdata_in;
        ADDR_SAMPLE_CTRL: nxt_st.sample_ctrl = wdata_in;
        ADDR_START_CTRL: if (wdata_in[START_BIT]) nxt_st.start_req = 1'b1;
        ADDR_CHAN_EN: nxt_st.chan_en = wdata_in[NUM_CHAN-1:0];
        ADDR_FW_SWITCH: nxt_st.fw_sw = wdata_in[NUM_SW-1:0];
        ADDR_HW_SWITCH: nxt_st.hw_sw = wdata_in[NUM_SW-1:0];
        ADDR_INTR: nxt_st.intr = st_ff.intr & ~wdata_in[NUM_INT-1:0];
        ADDR_INTR_SET: nxt_st.intr = st_ff.intr | wdata_in[NUM_INT-1:0];
        ADDR_INTR_MASK: nxt_st.mask = wdata_in[NUM_INT-1:0];
        default: ;
      endcase
    end
    if (trig_edge || st_ff.sample_ctrl[CONT_BIT]) nxt_st.start_req = 1'b1;
    // scan engine: fixed conversion slot per channel
    if (!st_ff.busy) begin
      if (st_ff.start_req || nxt_st.start_req) begin
        nxt_st.start_req = 1'b0;
        nxt_st.scan_en = en_now;
        nc = next_chan(en_now, 4'h0);
        if (nc[3]) begin
          ev[INT_EOS] = 1'b1;
        end else begin
          nxt_st.busy = 1'b1;
          nxt_st.chan = nc[2:0];
          nxt_st.cnt = CONV_CYCLES;
        end
      end
    end else begin
      if (st_ff.cnt == CONV_CYCLES) begin
        nxt_st.conv_start = 1'b1;
        nxt_st.conv_chan = st_ff.chan;
        nxt_st.conv_sel = dec_sel;
      end
      if (st_ff.cnt == 4'h0) begin
        nc = next_chan(st_ff.scan_en, 4'(st_ff.chan) + 4'h1);
        if (nc[3]) begin
          nxt_st.busy = 1'b0;
          ev[INT_EOS] = 1'b1;
        end else begin
          nxt_st.chan = nc[2:0];
          nxt_st.cnt = CONV_CYCLES;
        end
      end else begin
        nxt_st.cnt = st_ff.cnt - 4'h1;
      end
      if (st_ff.start_req) ev[INT_COLL] = 1'b1;
    end
    ev[INT_OVF] = overflow_evt_in;
    ev[INT_COLL] = ev[INT_COLL] | collision_evt_in;
    ev[INT_INJ] = inj_eoc_evt_in;
    ev[INT_RANGE] = range_evt_in;
    ev[INT_SAT] = sat_evt_in;
    // set wins over a same-cycle clear
    nxt_st.intr = nxt_st.intr | ev;
    // routing: sequencer only reaches switches it owns and when not disabled
    if (st_ff.busy && !st_ff.ctrl[SW_DISABLE_BIT]) seq_sw = st_ff.fw_sw;
    nxt_st.sw = (st_ff.fw_sw & ~st_ff.hw_sw) | (seq_sw & st_ff.hw_sw);
    nxt_st.neg = (st_ff.busy && !dec_sel.diff) ? st_ff.ctrl[NEGATIVE_INPUT_SELECT_LSB +: NEGATIVE_INPUT_SELECT_W] : NEGATIVE_INPUT_SELECT_VREF;
    nxt_st.irq = |(st_ff.intr & st_ff.mask);
    // register reads
    if (rd_in) begin
      case (addr_in)
        ADDR_CTRL: nxt_st.rdata = st_ff.ctrl;
        ADDR_SAMPLE_CTRL: nxt_st.rdata = st_ff.sample_ctrl;
        ADDR_CHAN_EN: nxt_st.rdata = 32'(st_ff.chan_en);
        ADDR_FW_SWITCH: nxt_st.rdata = 32'(st_ff.fw_sw);
        ADDR_HW_SWITCH: nxt_st.rdata = 32'(st_ff.hw_sw);
        ADDR_INTR: nxt_st.rdata = 32'(st_ff.intr);
        ADDR_INTR_SET: nxt_st.rdata = 32'(st_ff.intr);
        ADDR_INTR_MASK: nxt_st.rdata = 32'(st_ff.mask);
        ADDR_INTR_MASKED: nxt_st.rdata = 32'(st_ff.intr & st_ff.mask);
        ADDR_CAUSE: nxt_st.rdata = 32'(|(st_ff.intr & st_ff.mask));
        ADDR_STATUS: nxt_st.rdata = {23'h0, st_ff.busy, st_ff.scan_en};
        default: begin
          for (int i = 0; i < NUM_CHAN; i++) begin
            if (addr_in == ADDR_CHAN_CFG0 + 8'(4 * i)) nxt_st.rdata = chan_cfg_ff[i];
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_out = st_ff.rdata;
  assign switch_out = st_ff.sw;
  assign negative_input_select_out = st_ff.neg;
  assign conv_start_out = st_ff.conv_start;
  assign conv_chan_out = st_ff.conv_chan;
  assign conv_sel_out = st_ff.conv_sel;
  assign busy_out = st_ff.busy;
  assign irq_out = st_ff.irq;

  property p_irq;
    @(posedge clk_in) disable iff (!rst_n_in) |(st_ff.intr & st_ff.mask) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
  property p_irq_low;
    @(posedge clk_in) disable iff (!rst_n_in) !(|(st_ff.intr & st_ff.mask)) |=> !irq_out;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq stuck");
  property p_fw_sw;
    @(posedge clk_in) disable iff (!rst_n_in) (st_ff.hw_sw == '0) |=> (switch_out == $past(st_ff.fw_sw));
  endproperty
  a_fw_sw: assert property (p_fw_sw) else $error("firmware switch mismatch");
  property p_disable;
    @(posedge clk_in) disable iff (!rst_n_in) st_ff.ctrl[SW_DISABLE_BIT] |=> ((switch_out & $past(st_ff.hw_sw)) == '0);
  endproperty
  a_disable: assert property (p_disable) else $error("sequencer closed switch");
  property p_set;
    @(posedge clk_in) disable iff (!rst_n_in) (wr_in && addr_in == ADDR_INTR_SET) |=>
      ((st_ff.intr & $past(wdata_in[NUM_INT-1:0])) == $past(wdata_in[NUM_INT-1:0]));
  endproperty
  a_set: assert property (p_set) else $error("interrupt set lost");
  sequence s_start;
    !busy_out && st_ff.start_req && (st_ff.chan_en != '0) && !st_ff.ctrl[FABRIC_MODE_BIT];
  endsequence
  property p_start;
    @(posedge clk_in) disable iff (!rst_n_in) s_start |=> busy_out ##1 conv_start_out;
  endproperty
  a_start: assert property (p_start) else $error("scan did not start");
  property p_capture;
    @(posedge clk_in) disable iff (!rst_n_in) busy_out && $past(busy_out) |-> $stable(st_ff.scan_en);
  endproperty
  a_capture: assert property (p_capture) else $error("enable set changed in scan");
  property p_en;
    @(posedge clk_in) disable iff (!rst_n_in) conv_start_out |-> st_ff.scan_en[conv_chan_out];
  endproperty
  a_en: assert property (p_en) else $error("disabled channel converted");
  property p_avg;
    @(posedge clk_in) disable iff (!rst_n_in) cur_cfg[CFG_AVG_BIT] |-> dec_sel.res == RES_12;
  endproperty
  a_avg: assert property (p_avg) else $error("averaging not twelve bit");
  property p_res_full;
    @(posedge clk_in) disable iff (!rst_n_in) !cur_cfg[CFG_AVG_BIT] && !cur_cfg[CFG_RES_BIT] |-> dec_sel.res == RES_12;
  endproperty
  a_res_full: assert property (p_res_full) else $error("clear select not twelve bit");
  property p_res_alt;
    @(posedge clk_in) disable iff (!rst_n_in) !cur_cfg[CFG_AVG_BIT] && cur_cfg[CFG_RES_BIT] |->
      dec_sel.res == (st_ff.sample_ctrl[SUB_RES_BIT] ? RES_10 : RES_8);
  endproperty
  a_res_alt: assert property (p_res_alt) else $error("alternate resolution wrong");
  // firmware keeps every switch that hardware does not own
  property p_own;
    @(posedge clk_in) disable iff (!rst_n_in) 1'b1 |=>
      ((switch_out & ~$past(st_ff.hw_sw)) == ($past(st_ff.fw_sw) & ~$past(st_ff.hw_sw)));
  endproperty
  a_own: assert property (p_own) else $error("unowned switch not firmware");
  property p_neg_se;
    @(posedge clk_in) disable iff (!rst_n_in)
      conv_start_out && !conv_sel_out.diff |-> negative_input_select_out == $past(st_ff.ctrl[NEGATIVE_INPUT_SELECT_LSB +: NEGATIVE_INPUT_SELECT_W]);
  endproperty
  a_neg_se: assert property (p_neg_se) else $error("single-ended negative select wrong");
  property p_neg_diff;
    @(posedge clk_in) disable iff (!rst_n_in) conv_start_out && conv_sel_out.diff |-> negative_input_select_out == NEGATIVE_INPUT_SELECT_VREF;
  endproperty
  a_neg_diff: assert property (p_neg_diff) else $error("differential used negative select");
  // a scan ends when busy falls
  sequence s_scan_end;
    busy_out ##1 !busy_out;
  endsequence
  property p_eos;
    @(posedge clk_in) disable iff (!rst_n_in) s_scan_end |-> st_ff.intr[INT_EOS];
  endproperty
  a_eos: assert property (p_eos) else $error("end of scan not flagged");
endmodule : adc_seq_config

// File: bench/fabric_partner.sv
// fabric side model: trigger level and converter event pulses
`timescale 1ns/1ps
module fabric_partner (
  // bench commands
  input wire logic clk_in,
  input wire logic trig_req_in,
  input wire logic [4:0] evt_req_in,
  // toward the block
  output logic fabric_trig_out,
  output logic [4:0] evt_out
);
  logic [2:0] hold_ff = 3'h0;
  // trigger held a few cycles so the two-flop sync cannot miss it
  always @(posedge clk_in) begin
    hold_ff <= trig_req_in ? 3'h4 : (hold_ff != 3'h0 ? hold_ff - 3'h1 : 3'h0);
    fabric_trig_out <= trig_req_in || hold_ff > 3'h1;
    evt_out <= evt_req_in;
  end
endmodule : fabric_partner

// File: bench/testbench.sv
// self-checking bench for the adc sequencer configuration block
`timescale 1ns/1ps
module testbench;
  import adc_seq_pkg::*;
  logic clk_in, rst_n_in, wr_in, rd_in, trig_req, busy_out, irq_out, conv_start_out, fabric_trig_in;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, fabric_cfg_in, rv;
  logic [4:0] evt_req, evt;
  logic [NUM_SW-1:0] switch_out, cap_sw;
  logic [2:0] negative_input_select_out, conv_chan_out, cap_neg;
  chan_sel_t conv_sel_out;
  logic [2:0] ch_q[$];
  chan_sel_t sel_q[$];
  int failures, n_checks, cycles;
  adc_seq_config dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .fabric_trig_in,
    .fabric_cfg_in, .range_evt_in(evt[3]), .sat_evt_in(evt[4]), .overflow_evt_in(evt[0]),
    .collision_evt_in(evt[1]), .inj_eoc_evt_in(evt[2]), .switch_out, .negative_input_select_out, .conv_start_out,
    .conv_chan_out, .conv_sel_out, .busy_out, .irq_out);
  fabric_partner peer (.clk_in, .trig_req_in(trig_req), .evt_req_in(evt_req), .fabric_trig_out(fabric_trig_in),
    .evt_out(evt));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // record each launched conversion; timeout guards a hung scan
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (conv_start_out === 1'b1) begin
      ch_q.push_back(conv_chan_out);
      sel_q.push_back(conv_sel_out);
      cap_sw <= switch_out;
      cap_neg <= negative_input_select_out;
    end
    if (cycles == 30000) begin
      failures++;
      end_sim();
    end
  end
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
  endtask : rd
  task wait_scan;
    for (int i = 0; i < 40 && busy_out !== 1'b1; i++) @(posedge clk_in);
    chk("scan_busy", busy_out, 1);
    for (int i = 0; i < 300 && busy_out !== 1'b0; i++) @(posedge clk_in);
    chk("scan_done", busy_out, 0);
  endtask : wait_scan
  task scan(input logic [7:0] en);
    wr(ADDR_CHAN_EN, {24'h0, en});
    ch_q.delete();
    sel_q.delete();
    wr(ADDR_START_CTRL, 32'h1);
    wait_scan();
  endtask : scan
  task t_reset;
    chk("busy_rst", busy_out, 0);
    rd(ADDR_FW_SWITCH);
    chk("fw_sw_rst", rv, 0);
    rd(ADDR_HW_SWITCH);
    chk("hw_sw_rst", rv, 0);
    rd(8'h3c);
    chk("unmapped", rv, 0);
    wr(ADDR_FW_SWITCH, 32'h2000_0005);
    repeat (2) @(posedge clk_in);
    chk("fw_route", switch_out, 32'h2000_0005);
  endtask : t_reset
  task t_route;
    wr(ADDR_HW_SWITCH, 32'h1);
    wr(ADDR_CTRL, 32'h3 << NEGATIVE_INPUT_SELECT_LSB);
    wr(ADDR_CHAN_CFG0, 32'h0);
    repeat (2) @(posedge clk_in);
    chk("hw_idle", switch_out, 32'h2000_0004);
    scan(8'h01);
    chk("hw_busy", cap_sw, 32'h2000_0005);
    chk("neg_se", cap_neg, 3'h3);
    wr(ADDR_CHAN_CFG0, 32'h1 << CFG_DIFF_BIT);
    scan(8'h01);
    chk("neg_diff", cap_neg, 3'h7);
    wr(ADDR_CTRL, (32'h1 << SW_DISABLE_BIT) | (32'h7 << NEGATIVE_INPUT_SELECT_LSB));
    scan(8'h01);
    chk("sw_dis", cap_sw, 32'h2000_0004);
  endtask : t_route
  // every row of the resolution table, with time select and forward bits
  task t_res;
    logic sub, resb, avg;
    res_t exp;
    for (int i = 0; i < 5; i++) begin
      sub = i[0];
      resb = i < 2 || i == 4;
      avg = i == 4;
      exp = (avg || !resb) ? RES_12 : (sub ? RES_10 : RES_8);
      wr(ADDR_SAMPLE_CTRL, {31'h0, sub});
      wr(ADDR_CHAN_CFG0, (32'(resb) << CFG_RES_BIT) | (32'(avg) << CFG_AVG_BIT) | (32'h2 << CFG_ST_LSB)
        | (32'h1 << CFG_FWD_BIT));
      scan(8'h01);
      chk("sel", sel_q[0], {1'b0, 2'h2, exp, 1'b1});
    end
  endtask : t_res
  task t_enable;
    rd(ADDR_CHAN_CFG0);
    chk("cfg_rb", rv, 32'h4000_2600);
    wr(ADDR_INTR, 32'h3f);
    scan(8'h05);
    chk("n_chan", ch_q.size(), 2);
    chk("chan_a", ch_q[0], 0);
    chk("chan_b", ch_q[1], 2);
    rd(ADDR_INTR);
    chk("eos", rv[INT_EOS], 1);
    rd(ADDR_STATUS);
    chk("status", rv, 32'h05);
    ch_q.delete();
    sel_q.delete();
    wr(ADDR_START_CTRL, 32'h1);
    repeat (4) @(posedge clk_in);
    wr(ADDR_CHAN_EN, 32'h02);
    wr(ADDR_CHAN_CFG0 + 8'h04, 32'h1 << CFG_DIFF_BIT);
    wait_scan();
    chk("old_en", ch_q.size(), 2);
    chk("cfg_other", sel_q[1], 0);
    ch_q.delete();
    sel_q.delete();
    wr(ADDR_START_CTRL, 32'h1);
    wait_scan();
    chk("new_en_n", ch_q.size(), 1);
    chk("new_en", ch_q[0], 1);
    chk("new_cfg", sel_q[0], {1'b1, 2'h0, RES_12, 1'b0});
  endtask : t_enable
  task t_intr;
    wr(ADDR_INTR_MASK, 32'h0);
    wr(ADDR_INTR, 32'h3f);
    @(posedge clk_in) evt_req <= 5'h1f;
    @(posedge clk_in) evt_req <= 5'h0;
    repeat (3) @(posedge clk_in);
    rd(ADDR_INTR);
    chk("intr_raw", rv, 32'h3e);
    chk("irq_off", irq_out, 0);
    wr(ADDR_INTR_MASK, 32'h22);
    rd(ADDR_INTR_MASKED);
    chk("masked", rv, 32'h22);
    chk("irq_on", irq_out, 1);
    rd(ADDR_CAUSE);
    chk("cause", rv[0], 1);
    wr(ADDR_INTR, 32'h3f);
    rd(ADDR_INTR);
    chk("intr_clr", rv, 0);
    chk("irq_clr", irq_out, 0);
    wr(ADDR_INTR_SET, 32'h1);
    rd(ADDR_INTR_MASKED);
    chk("set_hidden", rv, 0);
    wr(ADDR_INTR_MASK, 32'h1);
    rd(ADDR_INTR_MASKED);
    chk("set_shown", rv, 1);
  endtask : t_intr
  task t_trig;
    wr(ADDR_CTRL, 32'h1 << FABRIC_MODE_BIT);
    wr(ADDR_SAMPLE_CTRL, 32'h1);
    wr(ADDR_CHAN_EN, 32'h0);
    fabric_cfg_in <= 32'h1 << CFG_RES_BIT;
    ch_q.delete();
    sel_q.delete();
    @(posedge clk_in) trig_req <= 1'b1;
    @(posedge clk_in) trig_req <= 1'b0;
    wait_scan();
    chk("fab_n", ch_q.size(), 8);
    chk("fab_sel", sel_q[7], {1'b0, 2'h0, RES_10, 1'b0});
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CHAN_EN, 32'h1);
    wr(ADDR_SAMPLE_CTRL, 32'h1 << CONT_BIT);
    wait_scan();
    wait_scan();
    wr(ADDR_SAMPLE_CTRL, 32'h0);
    for (int i = 0; i < 300 && busy_out !== 1'b0; i++) @(posedge clk_in);
    repeat (20) @(posedge clk_in);
    chk("cont_stop", busy_out, 0);
  endtask : t_trig
  task end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  // reset, then the scenarios in turn
  initial begin
    rst_n_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    trig_req = 1'b0;
    evt_req = 5'h0;
    fabric_cfg_in = 32'h0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_route();
    t_res();
    t_enable();
    t_intr();
    t_trig();
    end_sim();
  end
endmodule : testbench
